// ==== design/ldiws_pkg.sv ====
// Purpose: shared constants and types of the write-only two-wire slave front end
// Assumes: link logic runs on a free-running sampling clock, system logic on clk_in
// Notes:   single-bit field positions, codes and timing counts live here; multi-bit field slices are fixed in ldiws_top
package ldiws_pkg;

  // ==========================================================================
  // timing
  localparam int LINK_CLK_PERIOD_NS = 80;
  localparam int SYS_CLK_PERIOD_NS  = 10;
  localparam int GLITCH_MIN_NS      = 160;
  localparam int GLITCH_CYCLES      = (GLITCH_MIN_NS + LINK_CLK_PERIOD_NS - 1) / LINK_CLK_PERIOD_NS;
  localparam logic [1:0] GLITCH_LAST = 2'(GLITCH_CYCLES - 1);

  // ==========================================================================
  // byte layout
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
  localparam logic [5:0] SLAVE_UPPER    = 6'h1c;
  localparam int         ADDR_SEL_BIT   = 1;
  localparam int         ADDR_RW_BIT    = 0;
  localparam int         CTRL_MORE_BIT  = 7;
  localparam int         CTRL_TYPE_BIT  = 6;
  localparam logic [4:0] CMD_DEVSEL     = 5'h1c;
  localparam int         CMD_PTR_BIT    = 7;
  localparam logic [6:0] PTR_LAST       = 7'h3b;

  // ==========================================================================
  // types
  typedef enum logic [2:0] {BUS_IDLE, BUS_ADDR, BUS_RX, BUS_ACK, BUS_IGNORE} ldiws_bus_e;
  typedef enum logic [1:0] {PH_CTRL, PH_ONE, PH_ALL} ldiws_phase_e;

  typedef struct packed {
    logic       is_disp;
    logic [7:0] data;
    logic [6:0] ptr;
    logic [2:0] sub;
  } ldiws_xfer_s;

  typedef struct packed {
    logic [1:0] cnt;
    logic       lvl;
  } ldiws_filt_s;

  typedef struct packed {
    logic         sda_s1, sda_s2, scl_s1, scl_s2, sel_s1, sel_s2;
    logic [2:0]   sub_s1, sub_s2;
    ldiws_filt_s  sda_f, scl_f;
    logic         sda_p, scl_p;
    ldiws_bus_e   bus;
    ldiws_phase_e phase;
    logic [7:0]   shift;
    logic [3:0]   bit_cnt;
    logic         ack_drive;
    logic         data_type;
    logic [6:0]   ptr;
    logic [2:0]   sub_cnt;
    logic         active;
    ldiws_xfer_s  xfer;
    logic         tog;
  } ldiws_link_s;

  typedef struct packed {
    logic        tog_s1, tog_s2, tog_s3;
    logic        act_s1, act_s2;
    ldiws_xfer_s xfer;
    logic        cmd_pulse;
    logic        disp_pulse;
  } ldiws_sys_s;

  localparam ldiws_link_s LINK_RST = '{sda_s1: 1'b1, sda_s2: 1'b1, scl_s1: 1'b1, scl_s2: 1'b1,
                                       sda_f: '{cnt: 2'h0, lvl: 1'b1},
                                       scl_f: '{cnt: 2'h0, lvl: 1'b1},
                                       sda_p: 1'b1, scl_p: 1'b1,
                                       bus: BUS_IDLE, phase: PH_CTRL, default: '0};
  localparam ldiws_sys_s  SYS_RST  = '0;

endpackage

// ==== design/ldiws_top.sv ====
// Purpose: write-only two-wire slave front end of an lcd segment driver
// Assumes: link_clk_in samples the bus lines; clk_in runs the command/display side
// Notes:   only output on the data line is the acknowledge pull-down
`timescale 1ns/1ps

module ldiws_top (
  // system clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  // link sampling clock
  input  wire logic       link_clk_in,
  // two-wire bus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_b_out,
  // strap pins
  input  wire logic       address_select_pin_in,
  input  wire logic       sub_addr_in_0,
  input  wire logic       sub_addr_in_1,
  input  wire logic       sub_addr_in_2,
  // command side
  output logic            cmd_valid_out,
  output logic [7:0]      cmd_byte_out,
  // display side
  output logic            disp_wr_out,
  output logic [7:0]      disp_data_out,
  output logic [6:0]      disp_ptr_out,
  output logic [2:0]      disp_sub_out,
  // status
  output logic            busy_out
);

  // ==========================================================================
  // helpers
  function automatic ldiws_pkg::ldiws_filt_s filt(input ldiws_pkg::ldiws_filt_s cur,
                                                  input logic raw);
    ldiws_pkg::ldiws_filt_s res;
    res = cur;
    if (raw == cur.lvl) begin
      res.cnt = 2'h0;
    end else if (cur.cnt == ldiws_pkg::GLITCH_LAST) begin
      res.lvl = raw;
      res.cnt = 2'h0;
    end else begin
      res.cnt = cur.cnt + 2'h1;
    end
    return res;
  endfunction

  // ==========================================================================
  // link domain state
  ldiws_pkg::ldiws_link_s lq;
  ldiws_pkg::ldiws_link_s ld;

  logic       sda_f;
  logic       scl_f;
  logic       start_det;
  logic       stop_det;
  logic       scl_rise;
  logic       scl_fall;
  logic [7:0] rx_byte;
  logic       addr_ok;
  logic       sub_match;

  always_comb begin
    sda_f     = lq.sda_f.lvl;
    scl_f     = lq.scl_f.lvl;
    start_det = scl_f & lq.scl_p & lq.sda_p & ~sda_f;
    stop_det  = scl_f & lq.scl_p & ~lq.sda_p & sda_f;
    scl_rise  = scl_f & ~lq.scl_p;
    scl_fall  = ~scl_f & lq.scl_p;
    rx_byte   = lq.shift;
    addr_ok   = (rx_byte[7:2] == ldiws_pkg::SLAVE_UPPER) &&
                (rx_byte[ldiws_pkg::ADDR_SEL_BIT] == lq.sel_s2) &&
                (rx_byte[ldiws_pkg::ADDR_RW_BIT] == 1'b0);
    sub_match = (lq.sub_cnt == lq.sub_s2);
  end

  always_comb begin
    ld = lq;
    // two-flop synchronisers and glitch filters
    ld.sda_s1 = sda_in;
    ld.sda_s2 = lq.sda_s1;
    ld.scl_s1 = scl_in;
    ld.scl_s2 = lq.scl_s1;
    ld.sel_s1 = address_select_pin_in;
    ld.sel_s2 = lq.sel_s1;
    ld.sub_s1 = {sub_addr_in_2, sub_addr_in_1, sub_addr_in_0};
    ld.sub_s2 = lq.sub_s1;
    ld.sda_f  = filt(lq.sda_f, lq.sda_s2);
    ld.scl_f  = filt(lq.scl_f, lq.scl_s2);
    ld.sda_p  = sda_f;
    ld.scl_p  = scl_f;

    if (start_det) begin
      // start or repeated start restarts the address phase
      ld.bus       = ldiws_pkg::BUS_ADDR;
      ld.phase     = ldiws_pkg::PH_CTRL;
      ld.bit_cnt   = 4'h0;
      ld.ack_drive = 1'b0;
    end else if (stop_det) begin
      ld.bus       = ldiws_pkg::BUS_IDLE;
      ld.ack_drive = 1'b0;
    end else begin
      case (lq.bus)
        ldiws_pkg::BUS_ADDR,
        ldiws_pkg::BUS_RX: begin
          if (scl_rise && lq.bit_cnt != ldiws_pkg::BITS_PER_BYTE) begin
            ld.shift   = {lq.shift[6:0], sda_f};
            ld.bit_cnt = lq.bit_cnt + 4'h1;
          end
          if (scl_fall && lq.bit_cnt == ldiws_pkg::BITS_PER_BYTE) begin
            ld.bit_cnt = 4'h0;
            ld.bus     = ldiws_pkg::BUS_ACK;
            if (lq.bus == ldiws_pkg::BUS_ADDR) begin
              if (addr_ok) begin
                ld.ack_drive = 1'b1;
              end else begin
                ld.bus = ldiws_pkg::BUS_IGNORE;
              end
            end else begin
              case (lq.phase)
                ldiws_pkg::PH_CTRL: begin
                  ld.data_type = rx_byte[ldiws_pkg::CTRL_TYPE_BIT];
                  ld.phase     = rx_byte[ldiws_pkg::CTRL_MORE_BIT] ?
                                 ldiws_pkg::PH_ONE : ldiws_pkg::PH_ALL;
                  ld.ack_drive = 1'b1;
                end
                ldiws_pkg::PH_ONE,
                ldiws_pkg::PH_ALL: begin
                  if (lq.phase == ldiws_pkg::PH_ONE) begin
                    ld.phase = ldiws_pkg::PH_CTRL;
                  end
                  if (!lq.data_type) begin
                    ld.ack_drive    = 1'b1;
                    ld.xfer.is_disp = 1'b0;
                    ld.xfer.data    = rx_byte;
                    ld.xfer.ptr     = lq.ptr;
                    ld.xfer.sub     = lq.sub_cnt;
                    ld.tog          = ~lq.tog;
                    if (rx_byte[7:3] == ldiws_pkg::CMD_DEVSEL) begin
                      ld.sub_cnt = rx_byte[2:0];
                    end
                    if (!rx_byte[ldiws_pkg::CMD_PTR_BIT]) begin
                      ld.ptr = rx_byte[6:0];
                    end
                  end else begin
                    ld.ack_drive = sub_match;
                    if (sub_match) begin
                      ld.xfer.is_disp = 1'b1;
                      ld.xfer.data    = rx_byte;
                      ld.xfer.ptr     = lq.ptr;
                      ld.xfer.sub     = lq.sub_cnt;
                      ld.tog          = ~lq.tog;
                    end
                    if (lq.ptr >= ldiws_pkg::PTR_LAST) begin
                      ld.ptr     = 7'h00;
                      ld.sub_cnt = lq.sub_cnt + 3'h1;
                    end else begin
                      ld.ptr = lq.ptr + 7'h01;
                    end
                  end
                end
                default: begin
                  ld.phase = ldiws_pkg::PH_CTRL;
                end
              endcase
            end
          end
        end
        ldiws_pkg::BUS_ACK: begin
          // acknowledge clock: hold the pull-down until its falling edge
          if (scl_fall) begin
            ld.ack_drive = 1'b0;
            ld.bus       = ldiws_pkg::BUS_RX;
          end
        end
        ldiws_pkg::BUS_IDLE,
        ldiws_pkg::BUS_IGNORE: begin
          ld.ack_drive = 1'b0;
        end
        default: begin
          ld.bus       = ldiws_pkg::BUS_IDLE;
          ld.ack_drive = 1'b0;
        end
      endcase
    end

    ld.active = (ld.bus != ldiws_pkg::BUS_IDLE) && (ld.bus != ldiws_pkg::BUS_IGNORE);
  end

  always_ff @(posedge link_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lq <= ldiws_pkg::LINK_RST;
    end else begin
      lq <= ld;
    end
  end

  // ==========================================================================
  // open-drain data pin
  assign sda_out      = 1'b0;
  assign sda_oe_b_out = ~lq.ack_drive;

  // ==========================================================================
  // system domain: toggle crossing, payload held stable in the link domain
  ldiws_pkg::ldiws_sys_s sq;
  ldiws_pkg::ldiws_sys_s sd;

  always_comb begin
    sd            = sq;
    sd.tog_s1     = lq.tog;
    sd.tog_s2     = sq.tog_s1;
    sd.tog_s3     = sq.tog_s2;
    sd.act_s1     = lq.active;
    sd.act_s2     = sq.act_s1;
    sd.cmd_pulse  = 1'b0;
    sd.disp_pulse = 1'b0;
    if (sq.tog_s2 != sq.tog_s3) begin
      sd.xfer       = lq.xfer;
      sd.cmd_pulse  = ~lq.xfer.is_disp;
      sd.disp_pulse = lq.xfer.is_disp;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sq <= ldiws_pkg::SYS_RST;
    end else begin
      sq <= sd;
    end
  end

  // ==========================================================================
  // outputs
  assign cmd_valid_out = sq.cmd_pulse;
  assign cmd_byte_out  = sq.xfer.data;
  assign disp_wr_out   = sq.disp_pulse;
  assign disp_data_out = sq.xfer.data;
  assign disp_ptr_out  = sq.xfer.ptr;
  assign disp_sub_out  = sq.xfer.sub;
  assign busy_out      = sq.act_s2;

endmodule // ldiws_top

// ==== test/ldiws_master.sv ====
// Purpose: behavioural two-wire bus master that drives the front end
// Assumes: clk_in paces the bus; sda_in is the resolved data line
// Notes:   low phase about 800 ns, high phase about 500 ns
`timescale 1ns/1ps

module ldiws_master (
  // pacing clock and resolved line
  input  wire logic clk_in,
  input  wire logic sda_in,
  // bus drive, open drain values
  output logic      scl_out,
  output logic      sda_out
);
  // =========================================================================
  // idle lines start high
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // clock spike shorter than one sampling period, data held
  task automatic spike();
    @(posedge clk_in) scl_out <= 1'b1;
    hold(5);
    scl_out <= 1'b0;
    hold(40);
  endtask

  // =========================================================================
  // one bit: data changes only while the clock is low
  task automatic put(input logic s, output logic seen);
    @(posedge clk_in) sda_out <= s;
    hold(40);
    scl_out <= 1'b1;
    hold(25);
    seen = sda_in;
    hold(25);
    scl_out <= 1'b0;
    hold(40);
  endtask

  // start or repeated start
  task automatic start();
    @(posedge clk_in) sda_out <= 1'b1;
    hold(40);
    scl_out <= 1'b1;
    hold(50);
    sda_out <= 1'b0;
    hold(50);
    scl_out <= 1'b0;
    hold(40);
  endtask

  // end of transfer
  task automatic stop();
    @(posedge clk_in) sda_out <= 1'b0;
    hold(40);
    scl_out <= 1'b1;
    hold(50);
    sda_out <= 1'b1;
    hold(50);
  endtask

  // msb first, then one released acknowledge clock
  task automatic send(input logic [7:0] b, output logic ack);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      put(b[i], seen);
    end
    put(1'b1, seen);
    ack = !seen;
  endtask
endmodule // ldiws_master

// ==== test/ldiws_top_chk.sv ====
// Purpose: port-level assertions for the two-wire slave front end
// Assumes: bound into every ldiws_top instance
// Notes:   link properties on link_clk_in, output side on clk_in
`timescale 1ns/1ps

module ldiws_top_chk (
  // clocks and reset
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       link_clk_in,
  // bus and straps
  input  wire logic       scl_in,
  input  wire logic       sda_out,
  input  wire logic       sda_oe_b_out,
  input  wire logic       sub_addr_in_0,
  input  wire logic       sub_addr_in_1,
  input  wire logic       sub_addr_in_2,
  // user side
  input  wire logic       cmd_valid_out,
  input  wire logic       disp_wr_out,
  input  wire logic [2:0] disp_sub_out,
  input  wire logic       busy_out
);
  // =========================================================================
  // link side
  sda_const_a: assert property (@(posedge link_clk_in) disable iff (!rst_b_in)
    sda_out == 1'b0) else $error("data drive value not zero");
  ack_hold_a: assert property (@(posedge link_clk_in) disable iff (!rst_b_in)
    (!sda_oe_b_out && scl_in) |=> (!sda_oe_b_out || !scl_in)) else $error("ack dropped early");
  ack_edge_a: assert property (@(posedge link_clk_in) disable iff (!rst_b_in)
    $fell(sda_oe_b_out) |-> !scl_in) else $error("ack started with clock high");
  rel_edge_a: assert property (@(posedge link_clk_in) disable iff (!rst_b_in)
    $rose(sda_oe_b_out) |-> !scl_in) else $error("ack released with clock high");
  // =========================================================================
  // user side
  cmd_pulse_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    cmd_valid_out |=> !cmd_valid_out) else $error("command pulse too long");
  disp_pulse_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    disp_wr_out |=> !disp_wr_out) else $error("display pulse too long");
  type_excl_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !(cmd_valid_out && disp_wr_out)) else $error("byte given two types");
  disp_sub_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    disp_wr_out |-> disp_sub_out == {sub_addr_in_2, sub_addr_in_1, sub_addr_in_0})
    else $error("display write for other subaddress");
  busy_gate_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (cmd_valid_out || disp_wr_out) |-> busy_out) else $error("output while not addressed");
  ack_c: cover property (@(posedge link_clk_in) $fell(sda_oe_b_out));
  cmd_c: cover property (@(posedge clk_in) cmd_valid_out);
  disp_c: cover property (@(posedge clk_in) disp_wr_out);
endmodule // ldiws_top_chk

bind ldiws_top ldiws_top_chk u_ldiws_top_chk (.clk_in, .rst_b_in, .link_clk_in, .scl_in,
  .sda_out, .sda_oe_b_out, .sub_addr_in_0, .sub_addr_in_1, .sub_addr_in_2, .cmd_valid_out,
  .disp_wr_out, .disp_sub_out, .busy_out);

// ==== test/tb_ldiws_top.sv ====
// Purpose: self-checking bench for the two-wire slave front end
// Assumes: bus master model in ldiws_master
// Notes:   strap subaddress 2; select pin varied per case
`timescale 1ns/1ps

module tb_ldiws_top;
  logic       clk_in, link_clk_in, rst_b_in, sel_q, ack;
  logic [2:0] sub_q;
  logic       scl_m, sda_m, sda_w, sda_out, sda_oe_b_out, busy_out;
  logic       cmd_valid_out, disp_wr_out;
  logic [7:0] cmd_byte_out, disp_data_out;
  logic [6:0] disp_ptr_out;
  logic [2:0] disp_sub_out;
  int         fails, n_compared, n_cmd, n_disp, cycles;

  // =========================================================================
  // clocks, wire, instances
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  initial begin
    link_clk_in = 1'b0;
    #1;
    forever #40 link_clk_in = ~link_clk_in;
  end
  assign sda_w = sda_m & (sda_oe_b_out | sda_out);

  ldiws_master u_ldiws_master (.clk_in(clk_in), .sda_in(sda_w), .scl_out(scl_m),
    .sda_out(sda_m));
  ldiws_top u_ldiws_top (.clk_in(clk_in), .rst_b_in(rst_b_in), .link_clk_in(link_clk_in),
    .scl_in(scl_m), .sda_in(sda_w), .sda_out(sda_out), .sda_oe_b_out(sda_oe_b_out),
    .address_select_pin_in(sel_q), .sub_addr_in_0(sub_q[0]), .sub_addr_in_1(sub_q[1]),
    .sub_addr_in_2(sub_q[2]), .cmd_valid_out(cmd_valid_out), .cmd_byte_out(cmd_byte_out),
    .disp_wr_out(disp_wr_out), .disp_data_out(disp_data_out), .disp_ptr_out(disp_ptr_out),
    .disp_sub_out(disp_sub_out), .busy_out(busy_out));

  always @(posedge clk_in) begin
    n_cmd  <= n_cmd + int'(cmd_valid_out);
    n_disp <= n_disp + int'(disp_wr_out);
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fails++;
      report_and_stop();
    end
  end

  // =========================================================================
  // checking and verdict
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("compared %0d, mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic byte_ack(input logic [7:0] b, input logic exp);
    u_ldiws_master.send(b, ack);
    check(8'(ack), 8'(exp));
  endtask

  // =========================================================================
  // address match, select pin, read refusal, ignore until start
  task automatic t_addr();
    logic [7:0] tbl [5] = '{8'h70, 8'h72, 8'h71, 8'h60, 8'h72};
    logic       sel [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    logic       exp [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_in) sel_q <= sel[i];
      u_ldiws_master.start();
      byte_ack(tbl[i], exp[i]);
      byte_ack(8'h80, exp[i]);
      u_ldiws_master.stop();
    end
    @(posedge clk_in) sel_q <= 1'b0;
    $display("test t_addr done");
  endtask

  // chained and final control bytes with commands
  task automatic t_cmd();
    int n0;
    n0 = n_cmd;
    u_ldiws_master.start();
    u_ldiws_master.spike();
    byte_ack(8'h70, 1'b1);
    byte_ack(8'h80, 1'b1);
    byte_ack(8'hE2, 1'b1);
    byte_ack(8'h00, 1'b1);
    byte_ack(8'h11, 1'b1);
    byte_ack(8'h3A, 1'b1);
    check(cmd_byte_out, 8'h3A);
    check(8'(n_cmd - n0), 8'h03);
    u_ldiws_master.stop();
    $display("test t_cmd done");
  endtask

  // display bytes, pointer wrap, subaddress steering
  task automatic t_disp();
    int n0;
    n0 = n_disp;
    u_ldiws_master.start();
    byte_ack(8'h70, 1'b1);
    byte_ack(8'h40, 1'b1);
    check(8'(busy_out), 8'h01);
    byte_ack(8'hA5, 1'b1);
    check(disp_data_out, 8'hA5);
    check(8'(disp_ptr_out), 8'h3A);
    check(8'(disp_sub_out), 8'h02);
    byte_ack(8'h5A, 1'b1);
    check(8'(disp_ptr_out), 8'(ldiws_pkg::PTR_LAST));
    byte_ack(8'hC3, 1'b0);
    check(8'(n_disp - n0), 8'h02);
    u_ldiws_master.stop();
    repeat (20) @(posedge clk_in);
    check(8'(busy_out), 8'h00);
    $display("test t_disp done");
  endtask

  // one-shot display header, command after display, repeated start
  task automatic t_rstart();
    int n0;
    n0 = n_disp;
    u_ldiws_master.start();
    byte_ack(8'h70, 1'b1);
    byte_ack(8'h80, 1'b1);
    byte_ack(8'hE2, 1'b1);
    byte_ack(8'hC0, 1'b1);
    byte_ack(8'h99, 1'b1);
    check(disp_data_out, 8'h99);
    check(8'(disp_ptr_out), 8'h01);
    check(8'(disp_sub_out), 8'h02);
    byte_ack(8'h00, 1'b1);
    byte_ack(8'h05, 1'b1);
    check(cmd_byte_out, 8'h05);
    check(8'(busy_out), 8'h01);
    u_ldiws_master.start();
    byte_ack(8'h70, 1'b1);
    byte_ack(8'h40, 1'b1);
    byte_ack(8'h77, 1'b1);
    check(disp_data_out, 8'h77);
    check(8'(disp_ptr_out), 8'h05);
    check(8'(n_disp - n0), 8'h02);
    u_ldiws_master.stop();
    $display("test t_rstart done");
  endtask

  // =========================================================================
  // main sequence
  initial begin
    rst_b_in = 1'b0;
    sel_q = 1'b0;
    sub_q = 3'h2;
    fails = 0;
    n_compared = 0;
    n_cmd = 0;
    n_disp = 0;
    cycles = 0;
    repeat (10) @(posedge clk_in);
    rst_b_in <= 1'b1;
    repeat (10) @(posedge clk_in);
    check(8'(sda_oe_b_out), 8'h01);
    t_addr();
    t_cmd();
    t_disp();
    t_rstart();
    report_and_stop();
  end
endmodule // tb_ldiws_top
